/* src/rms_pkg.sv */
package rms_pkg;

  // ==========================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
  localparam int unsigned ALERT_LEAD_US    = 100;
  // lead time rounds down to whole cycles, at least one
  localparam int unsigned ALERT_LEAD_CYC   = (ALERT_LEAD_US * (CLK_FREQ_HZ / 1_000_000) > 0) ?
                                             ALERT_LEAD_US * (CLK_FREQ_HZ / 1_000_000) : 1;
  localparam int unsigned WAKE_TIMER_W     = 32;
  localparam logic [31:0] WAKE_TIMER_RST   = 32'h0000_0000;
  localparam int unsigned ACT_SEQ_CYC      = 16;

  // ==========================================================
  // modes
  typedef enum logic [2:0] {
    RMS_RESET,
    RMS_WAKE_SEQ,
    RMS_ACTIVE,
    RMS_SLEEP,
    RMS_ALERT_LEAD,
    RMS_RADIO
  } rms_mode_t;

  typedef enum logic [1:0] {
    RMS_BOOT_NONE,
    RMS_BOOT_ROM,
    RMS_BOOT_FLASH
  } rms_boot_t;

  // ==========================================================
  // power and clock enables
  typedef struct packed {
    logic regulators_on;
    logic hs_osc_on;
    logic ls_osc_on;
    logic core_run;
    logic ifaces_on;
    logic rf_on;
    logic ram_retain;
  } rms_power_t;

  // ==========================================================
  // radio request
  typedef struct packed {
    logic tx;
    logic rx;
  } rms_radio_req_t;

endpackage

/* src/rms_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - the radio event alert goes high 100 us before a transmit or receive event starts.
// - the radio event alert returns low as soon as the transmit or receive event ends.
// - while the external reset is asserted the block stays in reset with regulators, clocks and rf off.
// - on reset release the activation sequence runs and ends in active mode.
// - in sleep only a low-speed oscillator runs; high-speed oscillators and rf are off.
// - logic state and ram contents are retained through sleep.
// - sleep lasts until the wake-up timer expires, then active mode follows.
// - in active mode interfaces, supplies and the high-speed oscillator are on and the core runs.
// - radio mode is active plus rf on, doing either transmit or receive, never both.
// - the boot-select pin is sampled after reset; high starts the rom bootloader, low the flash application.
module rms_sequencer
  import rms_pkg::*;
#(
  parameter int unsigned LEAD_CYC = ALERT_LEAD_CYC,   // alert lead time in cycles
  parameter int unsigned SEQ_CYC  = ACT_SEQ_CYC       // activation sequence length
) (
  input  wire logic                    clock,             // 25 MHz system clock
  input  wire logic                    nrst,              // external reset, active low
  input  wire logic                    boot_select_pin,   // boot-select pin, asynchronous
  input  wire logic                    ls_xtal_sel,       // 1: low-speed crystal, 0: ring oscillator
  input  wire logic                    sleep_req,         // core asks to sleep, one cycle
  input  wire logic [WAKE_TIMER_W-1:0] sleep_cycles,      // wake-up timer load value
  input  wire rms_radio_req_t          radio_req,         // event request, one cycle pulse
  input  wire logic                    radio_done,        // event finished, one cycle pulse
  output rms_mode_t                    mode,              // current operating mode
  output rms_power_t                   power,             // power and clock enables
  output rms_boot_t                    boot_target,       // chosen boot image
  output logic                         ls_xtal_on,        // low-speed crystal enable
  output logic                         ls_ring_on,        // low-speed ring oscillator enable
  output logic                         rf_tx_en,          // transceiver transmitting
  output logic                         rf_rx_en,          // transceiver receiving
  output logic                         radio_req_ready,   // request can be taken
  output logic                         radio_event_alert  // alert to antenna switch
);

  // ==========================================================
  // boot pin synchroniser
  logic       boot_s1_q;
  logic       boot_s2_q;
  logic       boot_s3_q;
  logic       boot_stable;
  logic       boot_level;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      boot_s1_q <= 1'b0;
      boot_s2_q <= 1'b0;
      boot_s3_q <= 1'b0;
    end else begin
      boot_s1_q <= boot_select_pin;
      boot_s2_q <= boot_s1_q;
      boot_s3_q <= boot_s2_q;
    end
  end

  // a level counts only once stages two and three agree
  assign boot_stable = (boot_s2_q == boot_s3_q);
  assign boot_level  = boot_s3_q;

  // ==========================================================
  // mode machine
  rms_mode_t                 mode_q;
  rms_mode_t                 mode_d;
  rms_boot_t                 boot_q;
  rms_boot_t                 boot_d;
  logic [31:0]               cnt_q;
  logic [31:0]               cnt_d;
  logic [WAKE_TIMER_W-1:0]   wake_q;
  logic [WAKE_TIMER_W-1:0]   wake_d;
  logic                      is_tx_q;
  logic                      is_tx_d;
  logic                      req_valid;
  logic                      req_tx;
  logic                      seq_done;
  logic                      lead_done;
  logic                      wake_expired;

  // a request with both bits set is refused: one direction at a time
  assign req_valid    = radio_req.tx ^ radio_req.rx;
  assign req_tx       = radio_req.tx;
  assign seq_done     = (cnt_q >= 32'(SEQ_CYC - 1)) && boot_stable;
  assign lead_done    = (cnt_q >= 32'(LEAD_CYC - 1));
  assign wake_expired = (wake_q == WAKE_TIMER_RST);
  assign radio_req_ready = (mode_q == RMS_ACTIVE);

  always_comb begin
    mode_d  = mode_q;
    boot_d  = boot_q;
    cnt_d   = cnt_q + 32'h0000_0001;
    wake_d  = wake_q;
    is_tx_d = is_tx_q;
    case (mode_q)
      RMS_RESET: begin
        // first cycle after release starts the activation sequence
        mode_d = RMS_WAKE_SEQ;
        cnt_d  = 32'h0000_0000;
      end
      RMS_WAKE_SEQ: begin
        if (seq_done) begin
          mode_d = RMS_ACTIVE;
          cnt_d  = 32'h0000_0000;
          if (boot_q == RMS_BOOT_NONE) begin
            // strap taken once per reset, after the synchroniser settles
            boot_d = boot_level ? RMS_BOOT_ROM : RMS_BOOT_FLASH;
          end
        end
      end
      RMS_ACTIVE: begin
        cnt_d = 32'h0000_0000;
        if (req_valid) begin
          mode_d  = RMS_ALERT_LEAD;
          is_tx_d = req_tx;
        end else if (sleep_req) begin
          mode_d = RMS_SLEEP;
          wake_d = sleep_cycles;
        end
      end
      RMS_SLEEP: begin
        cnt_d = 32'h0000_0000;
        if (wake_expired) begin
          // wake returns through the short sequence so the hs oscillator settles
          mode_d = RMS_WAKE_SEQ;
        end else begin
          wake_d = wake_q - 1'b1;
        end
      end
      RMS_ALERT_LEAD: begin
        if (lead_done) begin
          mode_d = RMS_RADIO;
          cnt_d  = 32'h0000_0000;
        end
      end
      RMS_RADIO: begin
        cnt_d = 32'h0000_0000;
        if (radio_done) begin
          mode_d = RMS_ACTIVE;
        end
      end
      default: begin
        mode_d = RMS_RESET;
        cnt_d  = 32'h0000_0000;
      end
    endcase
  end

  // state registers except the wake timer hold through sleep; only nrst resets them all
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mode_q  <= RMS_RESET;
      boot_q  <= RMS_BOOT_NONE;
      cnt_q   <= 32'h0000_0000;
      wake_q  <= WAKE_TIMER_RST;
      is_tx_q <= 1'b0;
    end else begin
      mode_q  <= mode_d;
      boot_q  <= boot_d;
      cnt_q   <= cnt_d;
      wake_q  <= wake_d;
      is_tx_q <= is_tx_d;
    end
  end

  // ==========================================================
  // outputs from flip-flops
  rms_power_t pwr_d;
  rms_power_t pwr_q;
  logic       alert_d;
  logic       alert_q;
  logic       tx_q;
  logic       rx_q;
  logic       lsx_q;
  logic       lsr_q;
  logic       in_radio_d;

  assign in_radio_d = (mode_d == RMS_RADIO);

  always_comb begin
    pwr_d = '0;
    case (mode_d)
      RMS_RESET: begin
        pwr_d = '0;
      end
      RMS_SLEEP: begin
        pwr_d.ls_osc_on  = 1'b1;
        pwr_d.ram_retain = 1'b1;
      end
      RMS_WAKE_SEQ: begin
        pwr_d.regulators_on = 1'b1;
        pwr_d.hs_osc_on     = 1'b1;
        pwr_d.ls_osc_on     = 1'b1;
        pwr_d.ram_retain    = 1'b1;
      end
      RMS_ACTIVE, RMS_ALERT_LEAD, RMS_RADIO: begin
        pwr_d.regulators_on = 1'b1;
        pwr_d.hs_osc_on     = 1'b1;
        pwr_d.ls_osc_on     = 1'b1;
        pwr_d.core_run      = 1'b1;
        pwr_d.ifaces_on     = 1'b1;
        pwr_d.ram_retain    = 1'b1;
        pwr_d.rf_on         = in_radio_d;
      end
      default: begin
        pwr_d = '0;
      end
    endcase
  end

  // alert spans the lead time and the event, low everywhere else
  assign alert_d = (mode_d == RMS_ALERT_LEAD) || in_radio_d;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pwr_q   <= '0;
      alert_q <= 1'b0;
      tx_q    <= 1'b0;
      rx_q    <= 1'b0;
      lsx_q   <= 1'b0;
      lsr_q   <= 1'b0;
    end else begin
      pwr_q   <= pwr_d;
      alert_q <= alert_d;
      tx_q    <= in_radio_d && is_tx_d;
      rx_q    <= in_radio_d && !is_tx_d;
      lsx_q   <= pwr_d.ls_osc_on && ls_xtal_sel;
      lsr_q   <= pwr_d.ls_osc_on && !ls_xtal_sel;
    end
  end

  assign mode              = mode_q;
  assign power             = pwr_q;
  assign boot_target       = boot_q;
  assign ls_xtal_on        = lsx_q;
  assign ls_ring_on        = lsr_q;
  assign rf_tx_en          = tx_q;
  assign rf_rx_en          = rx_q;
  assign radio_event_alert = alert_q;

endmodule // rms_sequencer

/* tb/rms_ant_sw.sv */
`timescale 1ns/1ps
module rms_ant_sw (
  input  wire logic   clock,             // clk
  input  wire logic   nrst,              // reset
  input  wire logic   boot_rom,          // bench wants bootloader
  input  wire logic   radio_event_alert, // alert in
  input  wire logic   rf_tx_en,          // tx
  input  wire logic   rf_rx_en,          // rx
  output logic        boot_select_pin,   // strap
  output logic [15:0] lead_q             // settle cycles seen
);
  // strap stays low unless a scenario asks for the bootloader
  assign boot_select_pin = boot_rom;
  // the switch needs the lead to settle, so count it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) lead_q <= 16'h0000;
    else if (!radio_event_alert) lead_q <= 16'h0000;
    else if (!(rf_tx_en || rf_rx_en)) lead_q <= lead_q + 16'h0001;
  end
endmodule // rms_ant_sw

/* tb/rms_chk.sv */
`timescale 1ns/1ps
module rms_chk
  import rms_pkg::*;
#(
  parameter int unsigned LEAD_CYC = 8, // alert lead
  parameter int unsigned SEQ_CYC  = 4  // wake length
) (
  input wire logic           clock,             // clk
  input wire logic           nrst,              // reset
  input wire logic           boot_select_pin,   // strap
  input wire logic           sleep_req,         // sleep
  input wire rms_radio_req_t radio_req,         // event
  input wire logic           radio_done,        // end
  input wire rms_mode_t      mode,              // mode
  input wire rms_power_t     power,             // enables
  input wire rms_boot_t      boot_target,       // boot
  input wire logic           ls_xtal_on,        // xtal
  input wire logic           ls_ring_on,        // ring
  input wire logic           rf_tx_en,          // tx
  input wire logic           rf_rx_en,          // rx
  input wire logic           radio_req_ready,   // ready
  input wire logic           radio_event_alert  // alert
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // lead is counted rather than delayed: the real lead is far beyond a plain delay
  logic [31:0] lead_cnt_q; // lead cycles seen
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lead_cnt_q <= 32'h0000_0000;
    end else if (!radio_event_alert) begin
      lead_cnt_q <= 32'h0000_0000;
    end else if (!(rf_tx_en || rf_rx_en)) begin
      lead_cnt_q <= lead_cnt_q + 32'h0000_0001;
    end
  end
  a_alert_lead: assert property ($rose(rf_tx_en | rf_rx_en) |-> lead_cnt_q == 32'(LEAD_CYC))
    else $error("alert lead wrong");
  a_lead_bound: assert property (lead_cnt_q <= 32'(LEAD_CYC))
    else $error("alert lead too long");
  a_alert_ends: assert property (radio_done && mode == RMS_RADIO |=> !radio_event_alert && !rf_tx_en)
    else $error("alert not cleared");
  // no disable here: reset is the very condition under test
  a_reset_off: assert property (disable iff (1'b0) !nrst |-> mode == RMS_RESET && power == 7'h00)
    else $error("not off in reset");
  a_wake_active: assert property (mode == RMS_WAKE_SEQ && $past(mode) != RMS_WAKE_SEQ
    |-> ##[SEQ_CYC:40] mode == RMS_ACTIVE)
    else $error("activation stuck");
  a_sleep_power: assert property (mode == RMS_SLEEP |-> power == 7'h11 && (ls_xtal_on ^ ls_ring_on))
    else $error("sleep power wrong");
  a_sleep_keep: assert property (mode == RMS_SLEEP |-> $stable(boot_target))
    else $error("state lost in sleep");
  a_sleep_wake: assert property ($rose(mode == RMS_SLEEP) |-> ##[1:1000] mode == RMS_WAKE_SEQ)
    else $error("no wake");
  a_active_on: assert property (mode == RMS_ACTIVE |-> power == 7'h7d && radio_req_ready)
    else $error("active power wrong");
  a_radio_one: assert property ((rf_tx_en | rf_rx_en) |-> !(rf_tx_en && rf_rx_en) && power.rf_on)
    else $error("radio mode wrong");
  a_boot_pick: assert property ($changed(boot_target) |-> $past(boot_target) == RMS_BOOT_NONE
    && boot_target == ($past(boot_select_pin, 4) ? RMS_BOOT_ROM : RMS_BOOT_FLASH))
    else $error("boot choice wrong");
  a_alert_quiet: assert property (radio_event_alert |-> mode inside {RMS_ALERT_LEAD, RMS_RADIO})
    else $error("stray alert");
  c_tx: cover property (rf_tx_en);
  c_rx: cover property (rf_rx_en);
  c_wake: cover property (mode == RMS_SLEEP ##1 mode == RMS_WAKE_SEQ);
endmodule // rms_chk

bind rms_sequencer rms_chk #(.LEAD_CYC(LEAD_CYC), .SEQ_CYC(SEQ_CYC)) rms_chk_i (.*);

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import rms_pkg::*;
  localparam int unsigned LEAD = 8;
  logic clock = 0, nrst = 1, boot_rom = 0, ls_xtal_sel = 1, sleep_req = 0, radio_done = 0;
  logic [31:0] sleep_cycles = 32'h0000_0000;
  rms_radio_req_t radio_req = 2'h0;
  rms_mode_t mode;
  rms_power_t power;
  rms_boot_t boot_target;
  logic boot_select_pin, ls_xtal_on, ls_ring_on, rf_tx_en, rf_rx_en, radio_req_ready, radio_event_alert;
  logic [15:0] lead_q;
  int error_cnt = 0;
  int tests_run = 0;
  always #20 clock = ~clock;
  rms_sequencer #(.LEAD_CYC(LEAD), .SEQ_CYC(4)) rms_sequencer_i (.*);
  rms_ant_sw rms_ant_sw_i (.*);
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_mode(rms_mode_t m);
    for (int i = 0; i < 200 && mode !== m; i++) @(negedge clock);
    chk(mode, m);
  endtask
  task automatic t_reset(logic b);
    @(negedge clock);
    boot_rom = b;
    nrst = 0;
    repeat (16) @(negedge clock);
    chk({mode, power, radio_event_alert}, {RMS_RESET, 8'h00});
    nrst = 1;
    wait_mode(RMS_ACTIVE);
    chk(boot_target, b ? RMS_BOOT_ROM : RMS_BOOT_FLASH);
    chk({power, radio_event_alert}, 8'hfa);
    boot_rom = 0;
  endtask
  task automatic t_radio(rms_radio_req_t r);
    @(negedge clock);
    radio_req = r;
    @(negedge clock);
    radio_req = 2'h0;
    chk({radio_event_alert, rf_tx_en, rf_rx_en}, 3'h4);
    wait_mode(RMS_RADIO);
    chk(lead_q, 16'(LEAD));
    chk({rf_tx_en, rf_rx_en, power.rf_on}, {r, 1'b1});
    repeat (3) @(negedge clock);
    radio_done = 1;
    @(negedge clock);
    radio_done = 0;
    chk({radio_event_alert, rf_tx_en, rf_rx_en, mode}, {3'h0, RMS_ACTIVE});
  endtask
  task automatic t_refused;
    @(negedge clock);
    radio_req = 2'h3;
    @(negedge clock);
    radio_req = 2'h0;
    @(negedge clock);
    chk({radio_event_alert, mode}, {1'b0, RMS_ACTIVE});
  endtask
  task automatic t_sleep(logic sel);
    rms_boot_t b;
    @(negedge clock);
    ls_xtal_sel = sel;
    sleep_req = 1;
    sleep_cycles = 32'h0000_0014;
    @(negedge clock);
    sleep_req = 0;
    b = boot_target;
    chk({mode, power, ls_xtal_on, ls_ring_on}, {RMS_SLEEP, 7'h11, sel, !sel});
    repeat (19) @(negedge clock);
    chk(mode, RMS_SLEEP);
    wait_mode(RMS_WAKE_SEQ);
    wait_mode(RMS_ACTIVE);
    chk(boot_target, b);
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_reset(1);
    t_reset(0);
    t_radio(2'h2);
    t_radio(2'h1);
    t_refused;
    t_sleep(1);
    t_sleep(0);
    give_verdict;
  end
  // the whole run needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    give_verdict;
  end
endmodule // testbench
